// ==== common/ssp_pkg.sv ====
// constants, register map and state codes for the sync serial port
package ssp_pkg;

  // register addresses
  localparam logic [15:0] ADDR_CTRL = 16'h000a;
  localparam logic [15:0] ADDR_STAT = 16'h000b;
  localparam logic [15:0] ADDR_DATA = 16'h000c;

  // control register fields
  localparam int CTRL_SPE_BIT = 6;
  localparam int CTRL_MASTER_SELECT_BIT_BIT = 4;

  // status register fields
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_COL_BIT = 6;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // shift clock divider options: 2, 4, 8 or 16
  localparam int DIV_DEFAULT = 16;
  localparam int DIV_W = 4;

  // transfer length
  localparam int XFER_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CNT_RST = 3'h0;

  // idle levels of the clock and data pins
  localparam logic SCK_IDLE = 1'b1;
  localparam logic SDI_IDLE = 1'b1;

  // master clock generator states
  typedef enum logic [3:0] {
    MST_IDLE = 4'b0001,
    MST_LEAD = 4'b0010,
    MST_LOW = 4'b0100,
    MST_HIGH = 4'b1000
  } ssp_mst_e;

endpackage

// ==== common/ssp_pin_if.sv ====
// one pin passing through the three-stage input synchroniser
`timescale 1ns/100ps
interface ssp_pin_if;
  logic raw;
  logic lvl;
  modport drv (output raw, input lvl);
  modport syn (input raw, output lvl);
endinterface

// ==== hw/ssp_sync3.sv ====
// three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
module ssp_sync3 #(
  parameter logic RST_LVL = 1'b1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // pin in, filtered level out
  ssp_pin_if.syn pin
);

  logic s1;
  logic s2;
  logic s3;
  logic lvl;
  logic next_lvl;

  // only s2 and s3 are compared; s1 may be metastable
  always_comb begin
    next_lvl = lvl;
    if (s2 == s3) begin
      next_lvl = s2;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s1 <= RST_LVL;
      s2 <= RST_LVL;
      s3 <= RST_LVL;
      lvl <= RST_LVL;
    end else begin
      s1 <= pin.raw;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  assign pin.lvl = lvl;

endmodule

// ==== hw/ssp_top.sv ====
// synchronous three-wire serial port: registers, shifter, clocking
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module ssp_top #(
  parameter int CLK_DIV = ssp_pkg::DIV_DEFAULT,
  parameter bit MSB_FIRST = 1'b1,
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // general purpose port side
  input wire logic i_gpio_line5_data,
  output logic o_port_owns,
  // serial pins
  input wire logic i_portb_line6,
  input wire logic i_portb_line7,
  output logic o_portb_line5_o,
  output logic o_portb_line5_oe,
  output logic o_portb_line7_o,
  output logic o_portb_line7_oe
);

  localparam int HALF = CLK_DIV / 2;
  localparam logic [ssp_pkg::DIV_W-1:0] HALF_M1 =
    ssp_pkg::DIV_W'(HALF - 1);

  // pin synchronisers
  ssp_pin_if sck_pin();
  ssp_pin_if sdi_pin();

  assign sck_pin.raw = i_portb_line7;
  assign sdi_pin.raw = i_portb_line6;

  ssp_sync3 #(.RST_LVL(ssp_pkg::SCK_IDLE)) u_sck_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .pin(sck_pin)
  );

  ssp_sync3 #(.RST_LVL(ssp_pkg::SDI_IDLE)) u_sdi_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .pin(sdi_pin)
  );

  logic sck_lvl;
  logic sdi_lvl;

  assign sck_lvl = sck_pin.lvl;
  assign sdi_lvl = sdi_pin.lvl;

  // state
  logic port_enable_bit;
  logic master_select_bit;
  logic next_spe;
  logic next_master_select_bit;
  ssp_pkg::ssp_mst_e mst_st;
  ssp_pkg::ssp_mst_e next_mst_st;
  logic [ssp_pkg::DIV_W-1:0] div_cnt;
  logic [ssp_pkg::DIV_W-1:0] next_div_cnt;
  logic sck_q;
  logic next_sck_q;
  logic in_xfer;
  logic next_in_xfer;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic sdo_q;
  logic next_sdo_q;
  logic sck_prev;
  logic [7:0] serial_shift_data;
  logic [7:0] next_sdr;
  logic transfer_done_flag;
  logic next_transfer_done_flag;
  logic access_collision_flag;
  logic next_access_collision_flag;
  logic arm;
  logic next_arm;
  logic [7:0] next_rdata;
  logic next_l5_oe;
  logic next_l7_oe;

  // events
  logic wr_ctrl;
  logic rd_stat;
  logic sdr_acc;
  logic sdr_wr;
  logic abort;
  logic m_fall;
  logic m_rise;
  logic s_fall;
  logic s_rise;
  logic fall_ev;
  logic rise_ev;
  logic shift_ev;
  logic done_ev;
  logic tx_bit;

  // address decode
  always_comb begin
    wr_ctrl = i_wr && (i_addr == ADDR_W'(ssp_pkg::ADDR_CTRL));
    rd_stat = i_rd && (i_addr == ADDR_W'(ssp_pkg::ADDR_STAT));
    sdr_acc = (i_wr || i_rd) &&
      (i_addr == ADDR_W'(ssp_pkg::ADDR_DATA));
    sdr_wr = i_wr && (i_addr == ADDR_W'(ssp_pkg::ADDR_DATA));
  end

  // control register; mode comes from software only, no select pin
  always_comb begin
    next_spe = port_enable_bit;
    next_master_select_bit = master_select_bit;
    if (wr_ctrl) begin
      next_spe = i_wdata[ssp_pkg::CTRL_SPE_BIT];
      next_master_select_bit = i_wdata[ssp_pkg::CTRL_MASTER_SELECT_BIT_BIT];
    end
    abort = (port_enable_bit && !next_spe) || (master_select_bit && !next_master_select_bit);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      port_enable_bit <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_SPE_BIT];
      master_select_bit <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_MASTER_SELECT_BIT_BIT];
    end else begin
      port_enable_bit <= next_spe;
      master_select_bit <= next_master_select_bit;
    end
  end

  // master shift clock generator, half period is HALF cycles
  always_comb begin
    next_mst_st = mst_st;
    next_div_cnt = div_cnt;
    next_sck_q = sck_q;
    m_fall = 1'b0;
    m_rise = 1'b0;
    if (abort || !port_enable_bit || !master_select_bit) begin
      next_mst_st = ssp_pkg::MST_IDLE;
      next_sck_q = ssp_pkg::SCK_IDLE;
      next_div_cnt = HALF_M1;
    end else begin
      unique case (mst_st)
        ssp_pkg::MST_IDLE: begin
          if (sdr_wr) begin
            next_mst_st = ssp_pkg::MST_LEAD;
            next_div_cnt = HALF_M1;
          end
        end
        ssp_pkg::MST_LEAD, ssp_pkg::MST_HIGH: begin
          if (div_cnt == '0) begin
            next_mst_st = ssp_pkg::MST_LOW;
            next_sck_q = 1'b0;
            m_fall = 1'b1;
            next_div_cnt = HALF_M1;
          end else begin
            next_div_cnt = div_cnt - 1'b1;
          end
        end
        ssp_pkg::MST_LOW: begin
          if (div_cnt == '0) begin
            next_sck_q = 1'b1;
            m_rise = 1'b1;
            next_div_cnt = HALF_M1;
            if (bitcnt == ssp_pkg::LAST_BIT) begin
              next_mst_st = ssp_pkg::MST_IDLE;
            end else begin
              next_mst_st = ssp_pkg::MST_HIGH;
            end
          end else begin
            next_div_cnt = div_cnt - 1'b1;
          end
        end
        default: begin
          next_mst_st = ssp_pkg::MST_IDLE;
          next_sck_q = ssp_pkg::SCK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      mst_st <= ssp_pkg::MST_IDLE;
      div_cnt <= '0;
      sck_q <= ssp_pkg::SCK_IDLE;
    end else begin
      mst_st <= next_mst_st;
      div_cnt <= next_div_cnt;
      sck_q <= next_sck_q;
    end
  end

  // edge source by mode; the shifting itself is the same in both
  always_comb begin
    s_fall = port_enable_bit && !master_select_bit && !abort && sck_prev && !sck_lvl;
    s_rise = port_enable_bit && !master_select_bit && !abort && !sck_prev && sck_lvl;
    fall_ev = master_select_bit ? m_fall : s_fall;
    rise_ev = master_select_bit ? m_rise : s_rise;
    shift_ev = rise_ev && in_xfer;
    done_ev = shift_ev && (bitcnt == ssp_pkg::LAST_BIT);
    tx_bit = MSB_FIRST ? serial_shift_data[7] : serial_shift_data[0];
  end

  // transfer tracking and the data out stage
  always_comb begin
    next_in_xfer = in_xfer;
    next_bitcnt = bitcnt;
    next_sdo_q = sdo_q;
    if (abort || !port_enable_bit) begin
      next_in_xfer = 1'b0;
      next_bitcnt = ssp_pkg::CNT_RST;
    end else begin
      if (fall_ev) begin
        next_in_xfer = 1'b1;
        next_sdo_q = tx_bit;
      end
      if (done_ev) begin
        next_in_xfer = 1'b0;
        next_bitcnt = ssp_pkg::CNT_RST;
      end else if (shift_ev) begin
        next_bitcnt = bitcnt + 1'b1;
      end
    end
    // general purpose value seeds the pin when the port is switched on
    if (!port_enable_bit && next_spe) begin
      next_sdo_q = i_gpio_line5_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      in_xfer <= 1'b0;
      bitcnt <= ssp_pkg::CNT_RST;
      sdo_q <= 1'b0;
      sck_prev <= ssp_pkg::SCK_IDLE;
    end else begin
      in_xfer <= next_in_xfer;
      bitcnt <= next_bitcnt;
      sdo_q <= next_sdo_q;
      sck_prev <= sck_lvl;
    end
  end

  // shift data register; a write during a transfer simply wins
  always_comb begin
    next_sdr = serial_shift_data;
    if (sdr_wr) begin
      next_sdr = i_wdata;
    end else if (shift_ev) begin
      if (MSB_FIRST) begin
        next_sdr = {serial_shift_data[6:0], sdi_lvl};
      end else begin
        next_sdr = {sdi_lvl, serial_shift_data[7:1]};
      end
    end
  end

  // deliberately no reset
  always_ff @(posedge i_mclk) begin
    serial_shift_data <= next_sdr;
  end

  // status flags; setting beats clearing in the same cycle
  always_comb begin
    next_transfer_done_flag = transfer_done_flag;
    next_access_collision_flag = access_collision_flag;
    next_arm = arm;
    if (sdr_acc && arm) begin
      next_transfer_done_flag = 1'b0;
      next_access_collision_flag = 1'b0;
    end
    if (done_ev) begin
      next_transfer_done_flag = 1'b1;
    end
    if (sdr_acc && in_xfer) begin
      next_access_collision_flag = 1'b1;
    end
    if (rd_stat && transfer_done_flag) begin
      next_arm = 1'b1;
    end else if (sdr_acc) begin
      next_arm = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      transfer_done_flag <= ssp_pkg::STAT_RST[ssp_pkg::STAT_DONE_BIT];
      access_collision_flag <= ssp_pkg::STAT_RST[ssp_pkg::STAT_COL_BIT];
      arm <= 1'b0;
    end else begin
      transfer_done_flag <= next_transfer_done_flag;
      access_collision_flag <= next_access_collision_flag;
      arm <= next_arm;
    end
  end

  // read data and pin enables, all registered
  always_comb begin
    next_rdata = ssp_pkg::RDATA_RST;
    if (i_rd) begin
      if (i_addr == ADDR_W'(ssp_pkg::ADDR_CTRL)) begin
        next_rdata[ssp_pkg::CTRL_SPE_BIT] = port_enable_bit;
        next_rdata[ssp_pkg::CTRL_MASTER_SELECT_BIT_BIT] = master_select_bit;
      end else if (i_addr == ADDR_W'(ssp_pkg::ADDR_STAT)) begin
        next_rdata[ssp_pkg::STAT_DONE_BIT] = transfer_done_flag;
        next_rdata[ssp_pkg::STAT_COL_BIT] = access_collision_flag;
      end else if (i_addr == ADDR_W'(ssp_pkg::ADDR_DATA)) begin
        next_rdata = serial_shift_data;
      end
    end
    next_l5_oe = next_spe;
    next_l7_oe = next_spe && next_master_select_bit;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_rdata <= ssp_pkg::RDATA_RST;
      o_port_owns <= 1'b0;
      o_portb_line5_oe <= 1'b0;
      o_portb_line7_oe <= 1'b0;
    end else begin
      o_rdata <= next_rdata;
      o_port_owns <= next_spe;
      o_portb_line5_oe <= next_l5_oe;
      o_portb_line7_oe <= next_l7_oe;
    end
  end

  // master samples through the synchroniser, so at the fastest divide
  // the far end's data must already be stable a few cycles before the rise
  assign o_portb_line5_o = sdo_q;
  assign o_portb_line7_o = sck_q;

  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  idle_sck_high_a: assert property (
    (mst_st == ssp_pkg::MST_IDLE) |-> sck_q)
    else $error("master clock not high while idle");

  first_bit_out_a: assert property (
    fall_ev && !abort |=> (sdo_q == $past(tx_bit)))
    else $error("data out not updated on falling edge");

  sample_rise_a: assert property (
    shift_ev && !sdr_wr && MSB_FIRST |=> (serial_shift_data[0] == $past(sdi_lvl)))
    else $error("input bit not sampled on rising edge");

  eight_bits_a: assert property (
    done_ev |-> (bitcnt == 3'h7) && in_xfer)
    else $error("transfer ended on wrong edge count");

  div_rate_a: assert property (
    $rose(sck_q) && master_select_bit && port_enable_bit |-> $past(sck_q == 1'b0, HALF))
    else $error("master clock low phase wrong length");

  pin_dir_a: assert property (
    o_portb_line7_oe == (port_enable_bit && master_select_bit) && o_portb_line5_oe == port_enable_bit)
    else $error("pin direction does not follow control");

  abort_clear_a: assert property (
    !port_enable_bit |-> !in_xfer && (bitcnt == 3'h0))
    else $error("disable did not abort transfer");

  master_start_a: assert property (
    sdr_wr && port_enable_bit && master_select_bit && !abort && (mst_st == ssp_pkg::MST_IDLE)
    |=> (mst_st == ssp_pkg::MST_LEAD) ##[1:16] !sck_q)
    else $error("data write did not start master transfer");

  master_select_bit_abort_a: assert property (
    master_select_bit && wr_ctrl && !i_wdata[ssp_pkg::CTRL_MASTER_SELECT_BIT_BIT]
    |=> (mst_st == ssp_pkg::MST_IDLE) && !in_xfer)
    else $error("clearing master did not abort");

  done_set_a: assert property (
    done_ev |=> transfer_done_flag)
    else $error("done flag not set at last edge");

  done_clear_a: assert property (
    rd_stat && transfer_done_flag && !done_ev ##[1:2] sdr_acc && !done_ev |=> !transfer_done_flag)
    else $error("done flag not cleared by read sequence");

  collision_a: assert property (
    sdr_acc && in_xfer |=> access_collision_flag)
    else $error("collision flag not set");

  cover_master_c: cover property (done_ev && master_select_bit);
  cover_slave_c: cover property (done_ev && !master_select_bit);
  cover_collision_c: cover property ($rose(access_collision_flag));
  cover_abort_c: cover property (in_xfer && abort);

endmodule

// ==== bench/ssp_peer.sv ====
// far-side serial peripheral model for the port bench
`timescale 1ns/100ps
module ssp_peer #(
  parameter int HALF = 8
) (
  // clock
  input wire logic i_mclk,
  // serial wires
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi,
  output logic o_sck,
  // bench control
  input wire logic [7:0] i_tx,
  input wire logic i_load,
  input wire logic i_go,
  output logic [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  logic last = 1'b1;
  int rises = 0;
  int hold = 0;
  int tick = 0;
  int edges = 0;
  initial o_sdi = 1'b1;
  initial o_sck = 1'b1;
  initial o_rx = 8'h00;
  always @(posedge i_mclk) begin
    last <= i_sck;
    if (i_load) begin
      sh <= i_tx;
      rises <= 0;
    end else if (last && !i_sck) begin
      // new data only after a fall
      o_sdi <= sh[7];
      sh <= {sh[6:0], 1'b0};
    end
    if (!last && i_sck) begin
      o_rx <= {o_rx[6:0], i_sdo};
      rises <= rises + 1;
      if (rises == 7) hold <= 6;
    end else if (hold != 0) begin
      hold <= hold - 1;
      // hold time spent: the line must not keep showing the last bit
      if (hold == 1) o_sdi <= ~o_sdi;
    end
    // slave clock: 16 half periods, idles high
    if (i_go) begin
      edges <= 16;
      tick <= HALF;
    end else if (edges != 0) begin
      if (tick == 1) begin
        o_sck <= ~o_sck;
        edges <= edges - 1;
        tick <= HALF;
      end else tick <= tick - 1;
    end
  end
endmodule

// ==== bench/sync_serial_io_port_test.sv ====
// self-checking bench for the sync serial port
`timescale 1ns/100ps
module sync_serial_io_port_test;
  localparam int DIV = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gpio5 = 1'b0;
  logic load = 1'b0;
  logic go = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] rdata;
  logic [7:0] prx;
  logic owns, serial_data_out, sdo_oe, sck_o, sck_oe, psdi, psck, sck_w;
  logic [31:0] seed = 32'h4bc0577a;
  logic [7:0] v;
  int errors = 0;
  int compares = 0;
  int lowc = 0;

  // the shift clock wire: device drives it in master mode only
  assign sck_w = sck_oe ? sck_o : psck;
  always #2.5 clk = ~clk;

  ssp_top #(.CLK_DIV(DIV), .MSB_FIRST(1'b1), .ADDR_W(16)) i_ssp_top (
    .i_mclk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gpio_line5_data(gpio5),
    .o_port_owns(owns), .i_portb_line6(psdi), .i_portb_line7(sck_w),
    .o_portb_line5_o(serial_data_out), .o_portb_line5_oe(sdo_oe),
    .o_portb_line7_o(sck_o), .o_portb_line7_oe(sck_oe)
  );
  ssp_peer #(.HALF(8)) i_ssp_peer (
    .i_mclk(clk), .i_sck(sck_w), .i_sdo(serial_data_out), .o_sdi(psdi), .o_sck(psck),
    .i_tx(ptx), .i_load(load), .i_go(go), .o_rx(prx)
  );

  function automatic logic [31:0] rnd(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // register view of a byte that crossed the wire
  function automatic logic [7:0] order(input logic [7:0] x, input bit msb);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = x[7-i];
    return msb ? x : r;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // polling is bounded; a hung transfer shows as a status mismatch
  task automatic wait_done(input logic [7:0] exp);
    v = 8'h00;
    for (int n = 0; n < 300 && v[7] !== 1'b1; n++)
      rreg(ssp_pkg::ADDR_STAT, v);
    check(v, exp);
  endtask

  task automatic xfer(input logic [7:0] t, input logic [7:0] p, input bit sl);
    @(posedge clk);
    ptx <= p;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wreg(ssp_pkg::ADDR_DATA, t);
    if (sl) begin
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
    end
    wait_done(8'h80);
    rreg(ssp_pkg::ADDR_DATA, v);
    check(v, order(p, 1'b1));
    check(prx, order(t, 1'b1));
    check({7'h00, sck_w}, 8'h01);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
  endtask

  // every master low phase lasts half the divided period
  always @(posedge clk) begin
    if (sck_oe && !sck_o) lowc <= lowc + 1;
    else begin
      if (sck_oe && lowc != 0) check(lowc[7:0], 8'(DIV / 2));
      lowc <= 0;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rreg(ssp_pkg::ADDR_CTRL, v);
    check(v, 8'h00);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
    wreg(ssp_pkg::ADDR_STAT, 8'hff);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
    rreg(16'h000d, v);
    check(v, 8'h00);
    check({6'h00, sdo_oe, sck_oe}, 8'h00);
    @(posedge clk);
    gpio5 <= 1'b1;
    wreg(ssp_pkg::ADDR_CTRL, 8'h50);
    #1 check({4'h0, owns, sdo_oe, sck_oe, serial_data_out}, 8'h0f);
    rreg(ssp_pkg::ADDR_CTRL, v);
    check(v, 8'h50);
    xfer(8'h00, 8'hff, 1'b0);
    xfer(8'hff, 8'h00, 1'b0);
    repeat (4) begin
      seed = rnd(seed);
      xfer(seed[7:0], seed[15:8], 1'b0);
    end
    // overwrite in mid-flight: done and collision both end up set
    wreg(ssp_pkg::ADDR_DATA, seed[23:16]);
    repeat (40) @(posedge clk);
    wreg(ssp_pkg::ADDR_DATA, 8'h3c);
    wait_done(8'hc0);
    rreg(ssp_pkg::ADDR_DATA, v);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
    // disable mid-transfer frees the pins
    wreg(ssp_pkg::ADDR_DATA, 8'ha5);
    repeat (30) @(posedge clk);
    wreg(ssp_pkg::ADDR_CTRL, 8'h10);
    #1 check({4'h0, owns, sdo_oe, sck_oe, sck_o}, 8'h01);
    repeat (200) @(posedge clk);
    wreg(ssp_pkg::ADDR_CTRL, 8'h50);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
    // dropping master mid-transfer aborts too
    wreg(ssp_pkg::ADDR_DATA, 8'h5a);
    repeat (30) @(posedge clk);
    wreg(ssp_pkg::ADDR_CTRL, 8'h40);
    #1 check({6'h00, sck_oe, sdo_oe}, 8'h01);
    repeat (200) @(posedge clk);
    rreg(ssp_pkg::ADDR_STAT, v);
    check(v, 8'h00);
    repeat (2) begin
      seed = rnd(seed);
      xfer(seed[7:0], seed[15:8], 1'b1);
    end
    close_out();
  end
endmodule
